// ===== csync_chopper_sync.sv
`timescale 1ns/1ns
`include "csync_defines.svh"
// Function
// - Sync only with hysteresis or constant off-time chopper
// - Both coils wait for common sync pulse
// - Only lengthen off time, never cut cycles
// - Sync disabled above high-velocity threshold
// - One pulse every divider times 64 clocks
// - Four-bit divider, zero turns sync off
// - Analog scale bit selects external comparator reference
module csync_chopper_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Motion state from the ramp logic
  input wire csync_pkg::csync_vel_t motorVelocity,
  // Chopper handshake per coil: offDone = natural off time ended
  input wire logic [1:0] offDone,
  output logic [1:0] offRelease,
  // Comparator reference select, high = external analog input
  output logic useAnalogRef
);
  import csync_pkg::*;

  logic [31:0] ctrl_r; // Divider, chopper mode, quiet mode flag
  logic [31:0] high_velocity_threshold_r; // high_velocity_threshold
  logic [31:0] global_config_r; // global_config
  logic [7:0] awAddr_r; // Latched write address
  logic awHave_r; // Write address held
  logic [31:0] wData_r; // Latched write data
  logic [3:0] wStrb_r; // Latched strobes
  logic wHave_r; // Write data held
  logic bValid_r; // Write response pending
  logic [1:0] bResp_r; // Write response code
  logic rValid_r; // Read data pending
  logic [31:0] rData_r; // Read data
  logic [1:0] rResp_r; // Read response code
  logic syncPulse; // Common sync clock
  logic syncOn; // Synchronization in force
  csync_coil_e coil_r [2]; // Per-coil state
  logic [1:0] waiting; // Coils stretching now

  // Merge strobed bytes into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // Known register offset test, used by both channels
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `CSYNC_CTRL_OFS || a == `CSYNC_HIGH_VELOCITY_THRESHOLD_OFS ||
             a == `CSYNC_STAT_OFS || a == `CSYNC_GLOBAL_CONFIG_OFS;
  endfunction : mapped

  // Address and data taken independently, one write outstanding
  assign s_axi_awready = !awHave_r && !bValid_r;
  assign s_axi_wready = !wHave_r && !bValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Write address and data holding
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (awHave_r && wHave_r) begin
      awHave_r <= 1'b0; // Both consumed into a response
      wHave_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
    end
  end

  // Register update and write response; unmapped answers SLVERR
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= `CSYNC_CTRL_RST;
      high_velocity_threshold_r <= `CSYNC_HIGH_VELOCITY_THRESHOLD_RST;
      global_config_r <= `CSYNC_GLOBAL_CONFIG_RST;
      bValid_r <= 1'b0;
      bResp_r <= 2'b00;
    end else if (awHave_r && wHave_r) begin
      bValid_r <= 1'b1;
      bResp_r <= mapped(awAddr_r) ? 2'b00 : 2'b10;
      unique case (awAddr_r)
        `CSYNC_CTRL_OFS: begin
          ctrl_r <= merge(ctrl_r, wData_r, wStrb_r) & 32'h0000_003F;
        end
        `CSYNC_HIGH_VELOCITY_THRESHOLD_OFS: begin
          high_velocity_threshold_r <= merge(high_velocity_threshold_r, wData_r, wStrb_r);
        end
        `CSYNC_GLOBAL_CONFIG_OFS: begin
          global_config_r <= merge(global_config_r, wData_r, wStrb_r) & 32'h0000_0001;
        end
        default: begin
          // Status is read-only, others ignored
        end
      endcase
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // Read path, data registered one cycle after address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        `CSYNC_CTRL_OFS: rData_r <= ctrl_r;
        `CSYNC_HIGH_VELOCITY_THRESHOLD_OFS: rData_r <= high_velocity_threshold_r;
        `CSYNC_STAT_OFS: rData_r <= {29'h0000_0000, waiting, syncOn};
        `CSYNC_GLOBAL_CONFIG_OFS: rData_r <= global_config_r;
        default: rData_r <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // Shared sync clock
  csync_pulse_gen u_pulse (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .syncDiv(ctrl_r[`CSYNC_DIV_MSB:`CSYNC_DIV_LSB]),
    .syncPulse(syncPulse)
  );

  // Off in quiet mode, at divider zero, and above threshold
  assign syncOn = !ctrl_r[`CSYNC_QUIET_BIT]
                  && ctrl_r[`CSYNC_DIV_MSB:`CSYNC_DIV_LSB] != 4'h0
                  && motorVelocity <= high_velocity_threshold_r;

  // Reference select is a plain decode of the config bit
  assign useAnalogRef = global_config_r[`CSYNC_ASCALE_BIT];

  // Per-coil stretch: on offDone either release now or hold for pulse.
  // Release only follows offDone, so a cycle is never cut short.
  for (genvar c = 0; c < 2; c++) begin : g_coil
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        coil_r[c] <= CSYNC_FREE;
      end else begin
        unique case (coil_r[c])
          CSYNC_FREE: begin
            if (syncOn) coil_r[c] <= CSYNC_RUN;
          end
          CSYNC_RUN: begin
            if (!syncOn) coil_r[c] <= CSYNC_FREE;
            else if (offDone[c] && !syncPulse) coil_r[c] <= CSYNC_WAIT;
          end
          CSYNC_WAIT: begin
            if (syncPulse || !syncOn) coil_r[c] <= syncOn ? CSYNC_RUN : CSYNC_FREE;
          end
          default: coil_r[c] <= CSYNC_FREE;
        endcase
      end
    end
    assign waiting[c] = coil_r[c] == CSYNC_WAIT;
    // Free: pass through; run: pass only on a pulse; wait: pulse or sync going off ends it
    assign offRelease[c] = rst_n && ((coil_r[c] == CSYNC_FREE && offDone[c]) ||
                                     (coil_r[c] == CSYNC_RUN && offDone[c] && syncPulse) ||
                                     (waiting[c] && (syncPulse || !syncOn)));

    // While sync is on, a held coil is released only on the sync pulse
    wait_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (waiting[c] && syncOn && !syncPulse) |-> !offRelease[c])
      else $error("coil released between pulses");
    no_cut_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (coil_r[c] != CSYNC_WAIT && !offDone[c]) |-> !offRelease[c])
      else $error("chopper cycle cut short");
    wait_bounded_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(waiting[c]) |-> ##[1:960] offRelease[c])
      else $error("coil waited over a full period");
  end

  // Above threshold or quiet mode, coils return to free running
  sequence goesOff;
    motorVelocity > high_velocity_threshold_r || ctrl_r[`CSYNC_QUIET_BIT];
  endsequence
  high_velocity_threshold_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    goesOff |-> !syncOn ##1 (coil_r[0] == CSYNC_FREE || !$stable(high_velocity_threshold_r)))
    else $error("sync held above threshold");
  quiet_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl_r[`CSYNC_QUIET_BIT] |-> !syncOn) else $error("sync active in quiet mode");
  // Reference select moves only after a completed write to global_config
  ref_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$stable(useAnalogRef) |-> $past(awHave_r) && $past(wHave_r) &&
      $past(awAddr_r) == `CSYNC_GLOBAL_CONFIG_OFS)
    else $error("reference select changed without a write");
endmodule : csync_chopper_sync

// ===== csync_defines.svh
`ifndef CSYNC_DEFINES_SVH
`define CSYNC_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define CSYNC_CTRL_OFS 8'h00
`define CSYNC_HIGH_VELOCITY_THRESHOLD_OFS 8'h04
`define CSYNC_STAT_OFS 8'h08
`define CSYNC_GLOBAL_CONFIG_OFS 8'h0C

// Control register field positions
`define CSYNC_DIV_LSB 0
`define CSYNC_DIV_MSB 3
`define CSYNC_CHM_BIT 4
`define CSYNC_QUIET_BIT 5

// Global configuration field positions
`define CSYNC_ASCALE_BIT 0

// Reset values
`define CSYNC_CTRL_RST 32'h0000_0000
`define CSYNC_HIGH_VELOCITY_THRESHOLD_RST 32'h0000_0000
`define CSYNC_GLOBAL_CONFIG_RST 32'h0000_0000

// Clocks per divider step of the sync period
`define CSYNC_BASE_CYCLES 10'h040

`endif

// ===== csync_pkg.sv
package csync_pkg;
  // Sync divider value, zero means off
  typedef logic [3:0] csync_div_t;
  // Velocity word compared against the threshold
  typedef logic [31:0] csync_vel_t;
  // Off-time stretch state of one coil
  typedef enum logic [2:0] {
    CSYNC_RUN  = 3'b001,
    CSYNC_WAIT = 3'b010,
    CSYNC_FREE = 3'b100
  } csync_coil_e;
endpackage : csync_pkg

// ===== csync_pulse_gen.sv
`timescale 1ns/1ns
`include "csync_defines.svh"
module csync_pulse_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Divider and pulse
  input wire csync_pkg::csync_div_t syncDiv,
  output logic syncPulse
);
  import csync_pkg::*;

  // Period in clocks is divider times 64, so 14 bits suffice
  function automatic logic [13:0] periodOf(input csync_div_t d);
    periodOf = 14'({d, 6'h00});
  endfunction : periodOf

  logic [13:0] cnt_r; // Cycles since last pulse

  // Free-running counter, idle while divider is zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n || syncDiv == 4'h0) begin
      cnt_r <= 14'h0000;
    end else if (cnt_r >= periodOf(syncDiv) - 14'h0001) begin
      cnt_r <= 14'h0000; // Reload on the pulse
    end else begin
      cnt_r <= cnt_r + 14'h0001;
    end
  end

  // Pulse once per divider*64 clocks; a shrunk divider wraps at once
  assign syncPulse = rst_n && syncDiv != 4'h0 &&
                     cnt_r >= periodOf(syncDiv) - 14'h0001;

  // Check helpers: a gap counter of its own, so the period check does not
  // lean on cnt_r; armed_r waits for one pulse after any divider change
  logic [13:0] gap_r; // Cycles since the previous pulse
  logic armed_r; // A pulse seen under the present divider
  csync_div_t divSeen_r; // Divider one cycle ago

  // Gap counter and divider tracking for the period assertion
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gap_r <= 14'h0000;
      armed_r <= 1'b0;
      divSeen_r <= 4'h0;
    end else begin
      divSeen_r <= syncDiv;
      gap_r <= syncPulse ? 14'h0000 : gap_r + 14'h0001;
      if (syncDiv != divSeen_r) begin
        armed_r <= 1'b0; // Old spacing no longer applies
      end else if (syncPulse) begin
        armed_r <= 1'b1;
      end
    end
  end

  // A pulse under a settled divider, with a pulse before it
  sequence settledPulse;
    syncPulse && armed_r && syncDiv == divSeen_r;
  endsequence
  pulse_period_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    settledPulse |-> gap_r == 14'(syncDiv) * 14'(`CSYNC_BASE_CYCLES) - 14'h0001)
    else $error("sync period wrong");

  // No pulse while divider is zero
  div_zero_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    syncDiv == 4'h0 |-> !syncPulse) else $error("pulse with divider zero");
endmodule : csync_pulse_gen

// ===== tb_top.sv
`timescale 1ns/1ns
`include "csync_defines.svh"
module tb_top;
  import csync_pkg::*;
  // Clock, reset and register bus
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Chopper side
  csync_vel_t motorVelocity = 32'h0;
  logic [1:0] offDone = 2'h0;
  logic [1:0] offRelease;
  logic useAnalogRef;
  // Scoreboard counters and scratch
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  int n;

  csync_chopper_sync csync_chopper_sync_i (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .motorVelocity, .offDone, .offRelease,
    .useAnalogRef
  );

  // Free-running 20 MHz clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // One compare for every kind of value, widened to a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run, shared with the watchdog
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'h0);
  endtask : wr

  // Read: rready held until the data beat is sampled
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdw

  // One off-time end on the coils in m; cycles counted until all of them are let go
  task automatic coil(input logic [1:0] m, output int c);
    c = 0;
    @(posedge ref_clk) offDone <= m;
    @(negedge ref_clk);
    while (offRelease !== m && c < 2000) begin
      @(posedge ref_clk) offDone <= 2'h0;
      @(negedge ref_clk);
      c++;
    end
    @(posedge ref_clk) offDone <= 2'h0;
  endtask : coil

  // Later requests start two cycles after a pulse (release edge, then the
  // task's trailing edge), so each waits the period less two cycles
  task automatic period(input logic [1:0] m, output int c);
    coil(m, c);
    coil(m, c);
    coil(m, c);
  endtask : period

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdw(`CSYNC_CTRL_OFS, rd, rs); chk(rd, `CSYNC_CTRL_RST);
    rdw(`CSYNC_HIGH_VELOCITY_THRESHOLD_OFS, rd, rs); chk(rd, `CSYNC_HIGH_VELOCITY_THRESHOLD_RST);
    rdw(`CSYNC_GLOBAL_CONFIG_OFS, rd, rs); chk(rd, `CSYNC_GLOBAL_CONFIG_RST);
    // Unmapped word answers with a slave error and zero
    rdw(8'h10, rd, rs); chk({rs, rd[29:0]}, 32'h8000_0000);
    // Reference select follows the analog scale bit
    wr(`CSYNC_GLOBAL_CONFIG_OFS, 32'h1); chk(32'(useAnalogRef), 32'h1);
    wr(`CSYNC_GLOBAL_CONFIG_OFS, 32'h0); chk(32'(useAnalogRef), 32'h0);
    // Divider zero: no holding back at all
    coil(2'h3, n); chk(n, 0);
    // Period equals divider times 64, both coils together, then coil 0 alone
    for (int dv = 1; dv <= 15; dv += 7) begin
      wr(`CSYNC_CTRL_OFS, 32'(dv));
      period(2'h3, n); chk(n, dv * 64 - 2);
    end
    wr(`CSYNC_CTRL_OFS, 32'h1);
    period(2'h1, n); chk(n, 62);
    // No stray release while the coils stay quiet
    repeat (200) begin
      @(negedge ref_clk); chk(32'(offRelease), 32'h0);
    end
    // Chopper mode bit is stored and keeps sync working
    wr(`CSYNC_CTRL_OFS, 32'h11);
    rdw(`CSYNC_CTRL_OFS, rd, rs); chk(rd, 32'h11);
    rdw(`CSYNC_STAT_OFS, rd, rs); chk(rd, 32'h1);
    period(2'h3, n); chk(n, 62);
    // Quiet voltage mode: sync does not apply
    wr(`CSYNC_CTRL_OFS, 32'h21);
    rdw(`CSYNC_STAT_OFS, rd, rs); chk(rd, 32'h0);
    coil(2'h3, n); chk(n, 0);
    // Velocity threshold: equal keeps sync, above frees the coils
    wr(`CSYNC_CTRL_OFS, 32'h1);
    wr(`CSYNC_HIGH_VELOCITY_THRESHOLD_OFS, 32'd100);
    @(posedge ref_clk) motorVelocity <= 32'd101;
    coil(2'h3, n); chk(n, 0);
    rdw(`CSYNC_STAT_OFS, rd, rs); chk(rd, 32'h0);
    @(posedge ref_clk) motorVelocity <= 32'd100;
    period(2'h3, n); chk(n, 62);
    // Divider back to zero: coil 1 passes straight through again
    wr(`CSYNC_CTRL_OFS, 32'h0);
    coil(2'h2, n); chk(n, 0);
    end_of_test();
  end

  // Hang guard, well beyond the longest expected sequence
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
endmodule : tb_top
